//--- hdl/bni_node_device.sv
`timescale 1ns/1ns
module bni_node_device
   import bni_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [3:0] NODE_ID,
   input wire logic [3:0] BUS_NUM,
   input wire logic [7:0] BUS_ERR_EVT,
   input wire logic USER_IRQ,
   input wire logic RETRY_TIMEOUT,
   input wire logic STOP_CMD,
   input wire logic SELF_TEST_DONE,
   input wire logic SELF_TEST_OK,
   input wire logic [31:0] USER_RDATA,
   output logic USER_STB,
   output logic USER_WE,
   output logic [12:0] USER_OFFSET,
   output logic [31:0] USER_WDATA,
   output logic WIN_STB,
   output logic [17:0] WIN_OFFSET,
   bni_bus_if.device BUS
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [3:0] csr_ff, nxt_csr;
   logic [7:0] ber_ff, nxt_ber;
   logic [ICR_W-1:0] eicr_ff, nxt_eicr, uicr_ff, nxt_uicr;
   logic [31:0] idr_ff, nxt_idr;
   logic [2:0] bci_ff, nxt_bci;
   logic err_pend_ff, nxt_err_pend, usr_pend_ff, nxt_usr_pend;
   logic irq_req_ff, nxt_irq_req, irq_src_ff, nxt_irq_src;
   logic [15:0] irq_vec_ff, nxt_irq_vec;
   logic [3:0] irq_lvl_ff, nxt_irq_lvl;
   logic ack_ff, nxt_ack, uwait_ff, nxt_uwait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ustb_ff, nxt_ustb, uwe_ff, nxt_uwe, wstb_ff, nxt_wstb;
   logic [12:0] uoff_ff, nxt_uoff;
   logic [31:0] uwd_ff, nxt_uwd;
   logic [17:0] woff_ff, nxt_woff;

   logic [31:0] node_off, win_off;
   logic in_node, in_win, take, wr, user_acc;
   logic [12:0] off;
   logic err_set, usr_set, eicr_clr, uicr_clr, ack_now;

   function automatic logic hit(input logic t, input logic [12:0] a, input logic [12:0] o);
      return t && (a == o);
   endfunction

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   always_comb
   begin
      node_off = BUS.adr - node_base(BUS_NUM, NODE_ID);
      win_off = BUS.adr - win_base(BUS_NUM, NODE_ID);
      in_node = node_off < BNI_NODE_SIZE;
      in_win = win_off < BNI_WIN_SIZE;
      take = BUS.req && !ack_ff && !uwait_ff && (in_node || in_win);
      wr = take && in_node && BUS.we;
      off = node_off[12:0];
      user_acc = take && in_node && (off >= OFS_USER);
      eicr_clr = hit(wr, off, OFS_EICR) && (BUS.wdata[ICR_W-1:0] == eicr_ff);
      uicr_clr = hit(wr, off, OFS_UICR) && (BUS.wdata[ICR_W-1:0] == uicr_ff);
   end

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      nxt_csr = csr_ff;
      nxt_ber = ber_ff;
      nxt_eicr = eicr_ff;
      nxt_uicr = uicr_ff;
      nxt_idr = idr_ff;
      nxt_bci = bci_ff;
      nxt_ack = 1'b0;
      nxt_uwait = uwait_ff;
      nxt_rdata = rdata_ff;
      nxt_ustb = 1'b0;
      nxt_wstb = 1'b0;
      nxt_uwe = uwe_ff;
      nxt_uoff = uoff_ff;
      nxt_uwd = uwd_ff;
      nxt_woff = woff_ff;
      // Register writes; status bits of csr are read only
      if (hit(wr, off, OFS_CSR))
      begin
         nxt_csr[CSR_SEIE] = BUS.wdata[CSR_SEIE];
         nxt_csr[CSR_HEIE] = BUS.wdata[CSR_HEIE];
      end
      if (hit(wr, off, OFS_BER))
         nxt_ber = ber_ff & ~BUS.wdata[7:0];
      nxt_ber = nxt_ber | BUS_ERR_EVT;
      if (hit(wr, off, OFS_IDR))
         nxt_idr = BUS.wdata;
      if (hit(wr, off, OFS_BCICR))
         nxt_bci = BUS.wdata[2:0];
      if (hit(wr, off, OFS_EICR))
         nxt_eicr = eicr_clr ? '0 : BUS.wdata[ICR_W-1:0];
      if (hit(wr, off, OFS_UICR))
         nxt_uicr = uicr_clr ? '0 : BUS.wdata[ICR_W-1:0];
      if (SELF_TEST_DONE)
      begin
         nxt_csr[CSR_STS] = 1'b1;
         nxt_csr[CSR_BROKE] = !SELF_TEST_OK;
      end
      // User CSR and window accesses take one extra cycle for user data
      if (take && (user_acc || in_win))
      begin
         nxt_uwait = 1'b1;
         nxt_ustb = user_acc;
         nxt_wstb = in_win;
         nxt_uwe = BUS.we;
         nxt_uoff = off;
         nxt_uwd = BUS.wdata;
         nxt_woff = win_off[17:0];
      end
      else if (take)
      begin
         nxt_ack = 1'b1;
         case (off)
            OFS_CSR: nxt_rdata = 32'(csr_ff);
            OFS_BER: nxt_rdata = 32'(ber_ff);
            OFS_EICR: nxt_rdata = 32'(eicr_ff) | (32'(err_pend_ff) << ICR_PEND);
            OFS_IDR: nxt_rdata = idr_ff;
            OFS_UICR: nxt_rdata = 32'(uicr_ff) | (32'(usr_pend_ff) << ICR_PEND);
            OFS_BCICR: nxt_rdata = 32'(bci_ff);
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
      if (uwait_ff)
      begin
         nxt_uwait = 1'b0;
         nxt_ack = 1'b1;
         nxt_rdata = uwe_ff ? 32'h0000_0000 : USER_RDATA;
      end
   end

   // -------------------------------------------------------------
   // Interrupt pending and delivery
   // -------------------------------------------------------------
   always_comb
   begin
      ack_now = irq_req_ff && BUS.irq_ack;
      err_set = ((|(BUS_ERR_EVT & BER_SOFT)) && csr_ff[CSR_SEIE]) ||
                ((|(BUS_ERR_EVT & BER_HARD)) && csr_ff[CSR_HEIE]);
      err_set = err_set && (eicr_ff[ICR_LVL_TOP:ICR_LVL_LSB] != 4'h0);
      usr_set = USER_IRQ || (RETRY_TIMEOUT && bci_ff[BCI_RTO]) ||
                (STOP_CMD && bci_ff[BCI_STOP]) || (user_acc && bci_ff[BCI_UCSR]);
      usr_set = usr_set && (uicr_ff[ICR_LVL_TOP:ICR_LVL_LSB] != 4'h0);
      // New events win over clears and deliveries in the same cycle
      nxt_err_pend = err_set || (err_pend_ff && !eicr_clr && !(ack_now && !irq_src_ff));
      nxt_usr_pend = usr_set || (usr_pend_ff && !uicr_clr && !(ack_now && irq_src_ff));
      nxt_irq_req = irq_req_ff;
      nxt_irq_src = irq_src_ff;
      nxt_irq_vec = irq_vec_ff;
      nxt_irq_lvl = irq_lvl_ff;
      if (irq_req_ff)
      begin
         if (ack_now || (irq_src_ff ? uicr_clr : eicr_clr))
            nxt_irq_req = 1'b0;
      end
      // Nothing goes out while no target node is selected
      else if (idr_ff != 32'h0000_0000)
      begin
         if (err_pend_ff)
         begin
            nxt_irq_req = 1'b1;
            nxt_irq_src = 1'b0;
            nxt_irq_vec = eicr_ff[15:0];
            nxt_irq_lvl = eicr_ff[ICR_LVL_TOP:ICR_LVL_LSB];
         end
         else if (usr_pend_ff)
         begin
            nxt_irq_req = 1'b1;
            nxt_irq_src = 1'b1;
            nxt_irq_vec = uicr_ff[15:0];
            nxt_irq_lvl = uicr_ff[ICR_LVL_TOP:ICR_LVL_LSB];
         end
      end
   end

   // -------------------------------------------------------------
   // Registers; events while CE is low are not seen
   // -------------------------------------------------------------
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         csr_ff <= CSR_RST;
         ber_ff <= '0;
         eicr_ff <= '0;
         uicr_ff <= '0;
         idr_ff <= '0;
         bci_ff <= '0;
         err_pend_ff <= 1'b0;
         usr_pend_ff <= 1'b0;
         irq_req_ff <= 1'b0;
         irq_src_ff <= 1'b0;
         irq_vec_ff <= '0;
         irq_lvl_ff <= '0;
         ack_ff <= 1'b0;
         uwait_ff <= 1'b0;
         rdata_ff <= '0;
         ustb_ff <= 1'b0;
         uwe_ff <= 1'b0;
         wstb_ff <= 1'b0;
         uoff_ff <= '0;
         uwd_ff <= '0;
         woff_ff <= '0;
      end
      else if (CE)
      begin
         csr_ff <= nxt_csr;
         ber_ff <= nxt_ber;
         eicr_ff <= nxt_eicr;
         uicr_ff <= nxt_uicr;
         idr_ff <= nxt_idr;
         bci_ff <= nxt_bci;
         err_pend_ff <= nxt_err_pend;
         usr_pend_ff <= nxt_usr_pend;
         irq_req_ff <= nxt_irq_req;
         irq_src_ff <= nxt_irq_src;
         irq_vec_ff <= nxt_irq_vec;
         irq_lvl_ff <= nxt_irq_lvl;
         ack_ff <= nxt_ack;
         uwait_ff <= nxt_uwait;
         rdata_ff <= nxt_rdata;
         ustb_ff <= nxt_ustb;
         uwe_ff <= nxt_uwe;
         wstb_ff <= nxt_wstb;
         uoff_ff <= nxt_uoff;
         uwd_ff <= nxt_uwd;
         woff_ff <= nxt_woff;
      end
   end

   assign BUS.ack = ack_ff;
   assign BUS.rdata = rdata_ff;
   assign BUS.irq_req = irq_req_ff;
   assign BUS.irq_vec = irq_vec_ff;
   assign BUS.irq_lvl = irq_lvl_ff;
   assign BUS.irq_dest = idr_ff;
   assign USER_STB = ustb_ff;
   assign USER_WE = uwe_ff;
   assign USER_OFFSET = uoff_ff;
   assign USER_WDATA = uwd_ff;
   assign WIN_STB = wstb_ff;
   assign WIN_OFFSET = woff_ff;
endmodule

//--- shared/bni_pkg.sv
// Functional notes
// - Error flags clear by writing ones
// - Detected bus error sets its kind flag
// - Interrupts go only to one-hot target mask; code sends to any non-zero IDR mask
// - Error interrupts use error vector register
// - User interrupts use user vector register
// - Rewriting current contents clears, cancels pending
// - Zero level never interrupts; top bit highest
// - Host programs target, vectors before enables
// - Separate soft and hard error enables
// - Host enables hard, normally not soft
// - First 256 bytes required; user CSRs follow
// - Alert on retry timeout, stop, CSR access
// - Sixteen 256K windows from fixed base
// - Window from node ID times size
// - Bus number times stride plus I/O base
// - Self test pass sets passed, clears failed
package bni_pkg;
   // -------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------
   localparam logic [31:0] BNI_IO_BASE = 32'h2000_0000;
   localparam logic [31:0] BNI_WIN_BASE = 32'h2040_0000;
   localparam logic [31:0] BNI_BUS_STRIDE = 32'h0200_0000;
   localparam logic [31:0] BNI_WIN_SIZE = 32'h0004_0000;
   localparam logic [31:0] BNI_NODE_SIZE = 32'h0000_2000;
   localparam logic [12:0] OFS_CSR = 13'h0000;
   localparam logic [12:0] OFS_BER = 13'h0008;
   localparam logic [12:0] OFS_EICR = 13'h000C;
   localparam logic [12:0] OFS_IDR = 13'h0010;
   localparam logic [12:0] OFS_UICR = 13'h0014;
   localparam logic [12:0] OFS_BCICR = 13'h0018;
   localparam logic [12:0] OFS_USER = 13'h0100;
   // -------------------------------------------------------------
   // Fields and reset values
   // -------------------------------------------------------------
   localparam int CSR_STS = 0;
   localparam int CSR_BROKE = 1;
   localparam int CSR_SEIE = 2;
   localparam int CSR_HEIE = 3;
   localparam logic [3:0] CSR_RST = 4'h2;
   localparam logic [7:0] BER_SOFT = 8'h0F;
   localparam logic [7:0] BER_HARD = 8'hF0;
   localparam int ICR_W = 20;
   localparam int ICR_LVL_LSB = 16;
   localparam int ICR_LVL_TOP = 19;
   localparam int ICR_PEND = 23;
   localparam int BCI_STOP = 0;
   localparam int BCI_RTO = 1;
   localparam int BCI_UCSR = 2;
   // -------------------------------------------------------------
   // Timing and host sequence
   // -------------------------------------------------------------
   localparam logic [7:0] HOST_TIMEOUT = 8'h10;
   localparam logic [3:0] INIT_LAST = 4'hB;

   typedef enum logic [1:0] {H_IDLE, H_BUS, H_STEP} bni_hstate_t;

   function automatic logic [31:0] node_base(input logic [3:0] bus, input logic [3:0] id);
      return BNI_IO_BASE + BNI_BUS_STRIDE * 32'(bus) + BNI_NODE_SIZE * 32'(id);
   endfunction

   function automatic logic [31:0] win_base(input logic [3:0] bus, input logic [3:0] id);
      return BNI_WIN_BASE + BNI_BUS_STRIDE * 32'(bus) + BNI_WIN_SIZE * 32'(id);
   endfunction
endpackage

//--- shared/bni_bus_if.sv
`timescale 1ns/1ns
interface bni_bus_if;
   logic req;
   logic we;
   logic [31:0] adr;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;
   logic irq_req;
   logic [15:0] irq_vec;
   logic [3:0] irq_lvl;
   logic [31:0] irq_dest;
   logic irq_ack;
   modport device (
      input req, we, adr, wdata, irq_ack,
      output ack, rdata, irq_req, irq_vec, irq_lvl, irq_dest
   );
   modport host (
      output req, we, adr, wdata, irq_ack,
      input ack, rdata, irq_req, irq_vec, irq_lvl, irq_dest
   );
endinterface

//--- hdl/bni_node_host.sv
`timescale 1ns/1ns
module bni_node_host
   import bni_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [15:0] BUS_POS_WORD,
   input wire logic [3:0] HOST_NODE,
   input wire logic INIT_START,
   input wire logic [15:0] INIT_VECTOR,
   input wire logic [31:0] INIT_TARGET,
   input wire logic INIT_SOFT_EN,
   input wire logic [2:0] INIT_ALERTS,
   input wire logic CMD_REQ,
   input wire logic CMD_WE,
   input wire logic [12:0] CMD_OFFSET,
   input wire logic [31:0] CMD_WDATA,
   output logic BUSY,
   output logic DONE,
   output logic ERR,
   output logic [31:0] RDATA,
   output logic [31:0] WIN_BASE,
   output logic IRQ_STB,
   output logic [15:0] IRQ_VECTOR,
   output logic [3:0] IRQ_LEVEL,
   bni_bus_if.host BUS
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   bni_hstate_t st_ff, nxt_st;
   logic init_ff, nxt_init, req_ff, nxt_req, we_ff, nxt_we;
   logic [3:0] step_ff, nxt_step;
   logic [7:0] tmo_ff, nxt_tmo;
   logic [31:0] adr_ff, nxt_adr, wd_ff, nxt_wd, rd_ff, nxt_rd, win_ff, nxt_win;
   logic done_ff, nxt_done, err_ff, nxt_err, busy_ff, nxt_busy;
   logic iack_ff, nxt_iack, istb_ff, nxt_istb;
   logic [15:0] ivec_ff, nxt_ivec;
   logic [3:0] ilvl_ff, nxt_ilvl;
   logic [3:0] bus_no, node_no;
   logic s_we;
   logic [12:0] s_off;
   logic [31:0] s_wd, icr_val;

   // -------------------------------------------------------------
   // Init sequence table
   // -------------------------------------------------------------
   always_comb
   begin
      node_no = BUS_POS_WORD[3:0];
      bus_no = BUS_POS_WORD[7:4];
      icr_val = 32'(INIT_VECTOR) | (32'h0000_0001 << ICR_LVL_TOP);
      s_we = 1'b1;
      s_wd = rd_ff;
      // Target and both vectors precede the error enables
      case (step_ff)
         4'h0: begin s_we = 1'b0; s_off = OFS_BER; end
         4'h1: s_off = OFS_BER;
         4'h2: begin s_off = OFS_IDR; s_wd = INIT_TARGET; end
         4'h3: begin s_we = 1'b0; s_off = OFS_UICR; end
         4'h4: s_off = OFS_UICR;
         4'h5: begin s_off = OFS_UICR; s_wd = icr_val; end
         4'h6: begin s_we = 1'b0; s_off = OFS_EICR; end
         4'h7: s_off = OFS_EICR;
         4'h8: begin s_off = OFS_EICR; s_wd = icr_val; end
         4'h9: begin s_we = 1'b0; s_off = OFS_CSR; end
         4'hA:
         begin
            s_off = OFS_CSR;
            s_wd = rd_ff | (32'h0000_0001 << CSR_HEIE) | (32'(INIT_SOFT_EN) << CSR_SEIE);
         end
         default: begin s_off = OFS_BCICR; s_wd = 32'(INIT_ALERTS); end
      endcase
   end

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_init = init_ff;
      nxt_req = req_ff;
      nxt_we = we_ff;
      nxt_step = step_ff;
      nxt_tmo = tmo_ff;
      nxt_adr = adr_ff;
      nxt_wd = wd_ff;
      nxt_rd = rd_ff;
      nxt_done = 1'b0;
      nxt_err = 1'b0;
      nxt_win = win_base(bus_no, node_no);
      case (st_ff)
         H_IDLE:
         begin
            if (INIT_START)
            begin
               nxt_init = 1'b1;
               nxt_step = 4'h0;
               nxt_st = H_STEP;
            end
            else if (CMD_REQ)
            begin
               nxt_init = 1'b0;
               nxt_req = 1'b1;
               nxt_we = CMD_WE;
               nxt_adr = node_base(bus_no, node_no) + 32'(CMD_OFFSET);
               nxt_wd = CMD_WDATA;
               nxt_tmo = 8'h00;
               nxt_st = H_BUS;
            end
         end
         H_STEP:
         begin
            // A device that failed self test is not enabled
            if (step_ff == 4'hA && (!rd_ff[CSR_STS] || rd_ff[CSR_BROKE]))
            begin
               nxt_err = 1'b1;
               nxt_st = H_IDLE;
            end
            else
            begin
               nxt_req = 1'b1;
               nxt_we = s_we;
               nxt_adr = node_base(bus_no, node_no) + 32'(s_off);
               nxt_wd = s_wd;
               nxt_tmo = 8'h00;
               nxt_st = H_BUS;
            end
         end
         H_BUS:
         begin
            nxt_tmo = tmo_ff + 8'h01;
            if (BUS.ack)
            begin
               nxt_req = 1'b0;
               nxt_rd = BUS.rdata;
               if (init_ff && step_ff != INIT_LAST)
               begin
                  nxt_step = step_ff + 4'h1;
                  nxt_st = H_STEP;
               end
               else
               begin
                  nxt_done = 1'b1;
                  nxt_st = H_IDLE;
               end
            end
            else if (tmo_ff == HOST_TIMEOUT)
            begin
               nxt_req = 1'b0;
               nxt_err = 1'b1;
               nxt_st = H_IDLE;
            end
         end
         default: nxt_st = H_IDLE;
      endcase
      nxt_busy = (nxt_st != H_IDLE);
      // Only interrupts aimed at this node are taken
      nxt_iack = BUS.irq_req && BUS.irq_dest[HOST_NODE] && !iack_ff;
      nxt_istb = nxt_iack;
      nxt_ivec = nxt_iack ? BUS.irq_vec : ivec_ff;
      nxt_ilvl = nxt_iack ? BUS.irq_lvl : ilvl_ff;
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         st_ff <= H_IDLE;
         init_ff <= 1'b0;
         req_ff <= 1'b0;
         we_ff <= 1'b0;
         step_ff <= 4'h0;
         tmo_ff <= 8'h00;
         adr_ff <= '0;
         wd_ff <= '0;
         rd_ff <= '0;
         win_ff <= '0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         busy_ff <= 1'b0;
         iack_ff <= 1'b0;
         istb_ff <= 1'b0;
         ivec_ff <= '0;
         ilvl_ff <= '0;
      end
      else if (CE)
      begin
         st_ff <= nxt_st;
         init_ff <= nxt_init;
         req_ff <= nxt_req;
         we_ff <= nxt_we;
         step_ff <= nxt_step;
         tmo_ff <= nxt_tmo;
         adr_ff <= nxt_adr;
         wd_ff <= nxt_wd;
         rd_ff <= nxt_rd;
         win_ff <= nxt_win;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
         busy_ff <= nxt_busy;
         iack_ff <= nxt_iack;
         istb_ff <= nxt_istb;
         ivec_ff <= nxt_ivec;
         ilvl_ff <= nxt_ilvl;
      end
   end

   assign BUS.req = req_ff;
   assign BUS.we = we_ff;
   assign BUS.adr = adr_ff;
   assign BUS.wdata = wd_ff;
   assign BUS.irq_ack = iack_ff;
   assign BUSY = busy_ff;
   assign DONE = done_ff;
   assign ERR = err_ff;
   assign RDATA = rd_ff;
   assign WIN_BASE = win_ff;
   assign IRQ_STB = istb_ff;
   assign IRQ_VECTOR = ivec_ff;
   assign IRQ_LEVEL = ilvl_ff;
endmodule

//--- bench/bni_bus_properties.sv
`timescale 1ns/1ns
module bni_bus_properties (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] adr,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata,
   input wire logic irq_req,
   input wire logic [15:0] irq_vec,
   input wire logic [3:0] irq_lvl,
   input wire logic [31:0] irq_dest,
   input wire logic irq_ack
);
   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   logic wr;
   assign wr = req && we;
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("ack held over one cycle");
   a_ack_has_req: assert property (ack |-> $past(req))
      else $error("ack without request");
   a_ack_in_time: assert property ($rose(req) |-> ##[1:2] ack)
      else $error("ack late or missing");
   a_req_held: assert property (req && !ack |=> req && $stable(adr) && $stable(wdata))
      else $error("request changed before ack");
   // ----------------------------------------
   // Interrupt link
   // ----------------------------------------
   property p_irq_held;
      irq_req && !irq_ack && !req && !$past(req) |=> irq_req && $stable(irq_vec);
   endproperty
   property p_irq_fall;
      $fell(irq_req) |-> $past(irq_ack) || $past(wr) || $past(wr, 2) || $past(wr, 3);
   endproperty
   a_irq_dest_set: assert property (irq_req |-> irq_dest != 32'h0000_0000)
      else $error("interrupt sent with empty target mask");
   a_irq_level_set: assert property (irq_req |-> irq_lvl != 4'h0)
      else $error("interrupt sent with zero level");
   a_irq_req_held: assert property (p_irq_held)
      else $error("interrupt request dropped while pending");
   a_irq_ack_cause: assert property (irq_ack |-> $past(irq_req) && irq_req)
      else $error("accept without request");
   a_irq_drop_ack: assert property (irq_ack |=> !irq_req && !irq_ack)
      else $error("request not released after accept");
   a_irq_fall_cause: assert property (p_irq_fall)
      else $error("request dropped without accept or clear");
   c_irq_done: cover property (irq_ack);
   c_bus_write: cover property (ack && we);
   c_top_level: cover property (irq_req && irq_lvl[3]);
endmodule

//--- bench/tb_bus_node_interrupt_setup.sv
`timescale 1ns/1ns
module tb_bus_node_interrupt_setup
   import bni_pkg::*;
;
   localparam logic [15:0] VEC = 16'h0140;
   localparam logic [31:0] TARGET = 32'h0000_0004;
   logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, st_done = 1'b0, st_ok = 1'b0, usr_irq = 1'b0;
   logic rto = 1'b0, stop = 1'b0, init_start = 1'b0, cmd_req = 1'b0, cmd_we = 1'b0, soft_en = 1'b0;
   logic [2:0] alerts = 3'h7;
   logic [3:0] node_id = 4'h5, bus_num = 4'h3, host_node = 4'h2;
   logic [15:0] pos_word = 16'h0035, init_vec = VEC;
   logic [7:0] err_evt = 8'h00;
   logic [12:0] cmd_off = 13'h0000;
   logic [31:0] cmd_wd = 32'h0000_0000, usr_rd = 32'hA5A5_5A5A, target = TARGET;
   logic busy, done, err, user_stb, irq_stb, user_we;
   logic [12:0] user_off;
   logic [31:0] rdata, win_base, dest_seen, user_wd;
   logic [15:0] irq_vec, vec_seen;
   logic [3:0] irq_lvl, lvl_seen;
   int miscompares = 0, compares = 0, irq_cnt = 0, ustb_cnt = 0;
   bni_bus_if u_bni_bus_if ();
   bni_node_device u_bni_node_device (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .NODE_ID(node_id),
      .BUS_NUM(bus_num), .BUS_ERR_EVT(err_evt), .USER_IRQ(usr_irq), .RETRY_TIMEOUT(rto), .STOP_CMD(stop),
      .SELF_TEST_DONE(st_done), .SELF_TEST_OK(st_ok), .USER_RDATA(usr_rd), .USER_STB(user_stb), .USER_WE(user_we),
      .USER_OFFSET(user_off), .USER_WDATA(user_wd), .WIN_STB(), .WIN_OFFSET(), .BUS(u_bni_bus_if));
   bni_node_host u_bni_node_host (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .BUS_POS_WORD(pos_word),
      .HOST_NODE(host_node), .INIT_START(init_start), .INIT_VECTOR(init_vec), .INIT_TARGET(target),
      .INIT_SOFT_EN(soft_en), .INIT_ALERTS(alerts), .CMD_REQ(cmd_req), .CMD_WE(cmd_we), .CMD_OFFSET(cmd_off),
      .CMD_WDATA(cmd_wd), .BUSY(busy), .DONE(done), .ERR(err), .RDATA(rdata), .WIN_BASE(win_base),
      .IRQ_STB(irq_stb), .IRQ_VECTOR(irq_vec), .IRQ_LEVEL(irq_lvl), .BUS(u_bni_bus_if));
   bni_bus_properties u_bni_bus_properties (.CLK(clk), .SYS_RST(sys_rst), .req(u_bni_bus_if.req),
      .we(u_bni_bus_if.we), .adr(u_bni_bus_if.adr), .wdata(u_bni_bus_if.wdata), .ack(u_bni_bus_if.ack),
      .rdata(u_bni_bus_if.rdata), .irq_req(u_bni_bus_if.irq_req), .irq_vec(u_bni_bus_if.irq_vec),
      .irq_lvl(u_bni_bus_if.irq_lvl), .irq_dest(u_bni_bus_if.irq_dest), .irq_ack(u_bni_bus_if.irq_ack));
   always #4 clk = ~clk;
   // ----------------------------------------
   // Watchers and shared tasks
   // ----------------------------------------
   // Sampled mid-cycle so strobes are settled, not racing their launch edge
   always @(negedge clk)
   begin
      if (irq_stb === 1'b1)
      begin
         irq_cnt++;
         vec_seen = irq_vec;
         lvl_seen = irq_lvl;
         dest_seen = u_bni_bus_if.irq_dest;
      end
      if (user_stb === 1'b1)
         ustb_cnt++;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded so a lost DONE cannot hang the run
   task automatic wait_end(output logic e);
      int n;
      n = 0;
      while (done !== 1'b1 && err !== 1'b1 && n < 400)
      begin
         cyc(1);
         n++;
      end
      e = err;
      chk("finish", 32'h0000_0001, 32'(done | err));
      cyc(1);
   endtask
   task automatic cmd(input logic we, input logic [12:0] off, input logic [31:0] wd);
      logic e;
      cmd_we = we;
      cmd_off = off;
      cmd_wd = wd;
      cmd_req = 1'b1;
      cyc(1);
      cmd_req = 1'b0;
      wait_end(e);
      chk("cmd_err", 32'h0000_0000, 32'(e));
   endtask
   task automatic init(output logic e);
      init_start = 1'b1;
      cyc(1);
      init_start = 1'b0;
      wait_end(e);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(10);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_selftest;
      logic e;
      pulse(st_done);
      cmd(1'b0, OFS_CSR, 32'h0000_0000);
      chk("csr_fail", 32'h0000_0003, 32'(rdata[3:0]));
      init(e);
      chk("init_fail", 32'h0000_0001, 32'(e));
      st_ok = 1'b1;
      pulse(st_done);
      init(e);
      chk("init_ok", 32'h0000_0000, 32'(e));
      cmd(1'b0, OFS_CSR, 32'h0000_0000);
      chk("csr_ok", 32'h0000_0009, 32'(rdata[3:0]));
      chk("win_base", 32'h2654_0000, win_base);
   endtask
   task automatic t_error(input logic [7:0] ev, input int n_irq);
      int c0;
      c0 = irq_cnt;
      err_evt = ev;
      cyc(1);
      err_evt = 8'h00;
      cyc(10);
      chk("irq_cnt", 32'(c0 + n_irq), 32'(irq_cnt));
      if (n_irq == 1)
      begin
         chk("err_vec", 32'(VEC), 32'(vec_seen));
         chk("err_lvl", 32'h0000_0008, 32'(lvl_seen));
         chk("dest", TARGET, dest_seen);
      end
      cmd(1'b0, OFS_BER, 32'h0000_0000);
      chk("ber", 32'(ev), 32'(rdata[7:0]));
      cmd(1'b1, OFS_BER, rdata);
      cmd(1'b0, OFS_BER, 32'h0000_0000);
      chk("ber_clr", 32'h0000_0000, 32'(rdata[7:0]));
   endtask
   // User vector differs from the error vector so each source is told apart
   task automatic t_user;
      int c0;
      int u0;
      cmd(1'b1, OFS_UICR, 32'h0004_0180);
      c0 = irq_cnt;
      u0 = ustb_cnt;
      cmd(1'b1, OFS_USER + 13'h0008, 32'h1234_5678);
      chk("user_wd", 32'h1234_5678, user_wd);
      chk("user_we", 32'h0000_0001, 32'(user_we));
      cmd(1'b0, OFS_USER + 13'h0004, 32'h0000_0000);
      chk("user_rd", usr_rd, rdata);
      chk("user_off", 32'h0000_0104, 32'(user_off));
      chk("user_stb", 32'(u0 + 2), 32'(ustb_cnt));
      cyc(10);
      chk("csr_alert", 32'(c0 + 2), 32'(irq_cnt));
      pulse(stop);
      pulse(rto);
      pulse(usr_irq);
      chk("alerts", 32'(c0 + 5), 32'(irq_cnt));
      chk("user_vec", 32'h0000_0180, 32'(vec_seen));
      chk("user_lvl", 32'h0000_0004, 32'(lvl_seen));
   endtask
   task automatic t_cancel;
      int c0;
      cmd(1'b1, OFS_IDR, 32'h0000_0000);
      t_error(8'h10, 0);
      c0 = irq_cnt;
      cmd(1'b0, OFS_EICR, 32'h0000_0000);
      chk("eicr", {8'h00, 4'h8, 4'h8, VEC}, rdata);
      cmd(1'b1, OFS_EICR, rdata);
      cmd(1'b0, OFS_EICR, 32'h0000_0000);
      chk("eicr_clr", 32'h0000_0000, rdata);
      cmd(1'b1, OFS_IDR, TARGET);
      cyc(10);
      chk("cancel", 32'(c0), 32'(irq_cnt));
      t_error(8'h10, 0);
   endtask
   task automatic test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      cyc(2);
      t_selftest;
      t_user;
      t_error(8'h10, 1);
      t_error(8'h01, 0);
      t_cancel;
      test_done;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done;
   end
endmodule
